// ===== core/idp_addr_gen.sv
// Purpose : effective address and pointer step for one indirect access mode
// Assumes : accumulator taken as unsigned, sums wrap at 12 bits
// Notes   : purely combinational

`timescale 1ns/1ps

module idp_addr_gen
	import idp_pkg::*;
(
	input  wire logic [11:0]       ptrValue,   // current pointer
	input  wire idp_pkg::idp_amode_t amode,    // access mode
	input  wire logic [7:0]        accum,      // working accumulator
	output logic [11:0]            accessAddr, // memory address to use
	output logic                   stepNeeded, // pointer must move
	output logic                   stepDown    // move is a decrement
);
	import idp_pkg::*;

	// ==========================================================
	// mode decode
	always_comb begin
		accessAddr = ptrValue;
		stepNeeded = 1'b0;
		stepDown   = 1'b0;
		case (amode)
			IDP_AM_PRE_INCREMENT_ACCESS: begin
				accessAddr = 12'(ptrValue + 12'h001);
				stepNeeded = 1'b1;
			end
			IDP_AM_POST_INCREMENT_ACCESS: begin
				stepNeeded = 1'b1;
			end
			IDP_AM_POST_DECREMENT_ACCESS: begin
				stepNeeded = 1'b1;
				stepDown   = 1'b1;
			end
			IDP_AM_INDEXED: begin
				accessAddr = 12'(ptrValue + {4'h0, accum});
			end
			default: begin
				accessAddr = ptrValue;
			end
		endcase
	end

endmodule // idp_addr_gen

// ===== core/idp_indirect_unit.sv
// Purpose : indirect data memory addressing with three pointers, APB slave
// Assumes : data memory answers a read strobe with data in the next cycle
// Notes   : one APB transfer in flight; memory accesses are serialised

`timescale 1ns/1ps

module idp_indirect_unit
	import idp_pkg::*;
(
	input  wire logic        clk_sys,    // core clock, 40 MHz
	input  wire logic        sys_rst,    // synchronous reset, active high
	input  wire logic        psel,       // APB select
	input  wire logic        penable,    // APB access phase
	input  wire logic        pwrite,     // APB direction, high is write
	input  wire logic [7:0]  paddr,      // APB byte address
	input  wire logic [31:0] pwdata,     // APB write data
	output logic [31:0]      prdata,     // APB read data
	output logic             pready,     // APB transfer done
	output logic             pslverr,    // APB error, unmapped address
	output logic [11:0]      memAddr,    // data memory address
	output logic [7:0]       memWrData,  // data memory write byte
	output logic             memWrEn,    // data memory write strobe
	output logic             memRdEn,    // data memory read strobe
	input  wire logic [7:0]  memRdData,  // data memory read byte
	output logic [3:0]       bankSelect  // memory bank selector value
);
	import idp_pkg::*;

	// ==========================================================
	// state
	typedef struct packed {
		idp_state_t  state;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic [11:0] memAddr;
		logic [7:0]  memWrData;
		logic        memWrEn;
		logic        memRdEn;
		logic        isWrite;
		logic [7:0]  accum;
		logic [3:0]  bank;
	} idp_unit_state_t;

	idp_unit_state_t q;
	idp_unit_state_t d;

	// ==========================================================
	// address decode
	function automatic idp_dec_t decodeReg(input logic [7:0] a);
		idp_dec_t   r;
		logic [4:0] slot;
		r.kind   = IDP_RK_NONE;
		r.ptrIdx = a[6:5];
		r.amode  = IDP_AM_PLAIN;
		slot     = a[4:0];
		if (a == IDP_OFS_ACCUM) begin
			r.kind = IDP_RK_ACCUM;
		end else if (a == IDP_OFS_BANK) begin
			r.kind = IDP_RK_BANK;
		end else if (a >= IDP_PTR_BLK_END) begin
			r.kind = IDP_RK_NONE;
		end else if (slot == IDP_SLOT_PLAIN) begin
			r.kind  = IDP_RK_VIRTUAL;
			r.amode = IDP_AM_PLAIN;
		end else if (slot == IDP_SLOT_POST_INCREMENT_ACCESS) begin
			r.kind  = IDP_RK_VIRTUAL;
			r.amode = IDP_AM_POST_INCREMENT_ACCESS;
		end else if (slot == IDP_SLOT_POST_DECREMENT_ACCESS) begin
			r.kind  = IDP_RK_VIRTUAL;
			r.amode = IDP_AM_POST_DECREMENT_ACCESS;
		end else if (slot == IDP_SLOT_PRE_INCREMENT_ACCESS) begin
			r.kind  = IDP_RK_VIRTUAL;
			r.amode = IDP_AM_PRE_INCREMENT_ACCESS;
		end else if (slot == IDP_SLOT_INDEXED) begin
			r.kind  = IDP_RK_VIRTUAL;
			r.amode = IDP_AM_INDEXED;
		end else if (slot == IDP_SLOT_HIGH) begin
			r.kind = IDP_RK_HIGH;
		end else if (slot == IDP_SLOT_LOW) begin
			r.kind = IDP_RK_LOW;
		end else begin
			r.kind = IDP_RK_NONE;
		end
		return r;
	endfunction

	idp_dec_t    dec;
	logic        accessReq;
	logic [11:0] ptrValue   [IDP_NUM_PTR];
	logic [11:0] calcAddr   [IDP_NUM_PTR];
	logic        stepNeeded [IDP_NUM_PTR];
	logic        stepDown   [IDP_NUM_PTR];
	logic        ptrLoadHi  [IDP_NUM_PTR];
	logic        ptrLoadLo  [IDP_NUM_PTR];
	logic        ptrStep    [IDP_NUM_PTR];

	// decode of the current bus request
	assign dec       = decodeReg(paddr);
	assign accessReq = psel & penable;

	// ==========================================================
	// pointers and their address generators
	genvar gi;
	generate
		for (gi = 0; gi < IDP_NUM_PTR; gi++) begin : gPtr
			idp_pointer uPtr (
				.clk_sys  (clk_sys),
				.sys_rst  (sys_rst),
				.loadHigh (ptrLoadHi[gi]),
				.loadLow  (ptrLoadLo[gi]),
				.wrData   (pwdata[7:0]),
				.stepEn   (ptrStep[gi]),
				.stepDown (stepDown[gi]),
				.ptrValue (ptrValue[gi])
			);

			idp_addr_gen uGen (
				.ptrValue   (ptrValue[gi]),
				.amode      (dec.amode),
				.accum      (q.accum),
				.accessAddr (calcAddr[gi]),
				.stepNeeded (stepNeeded[gi]),
				.stepDown   (stepDown[gi])
			);
		end
	endgenerate

	// ==========================================================
	// transfer sequencer
	always_comb begin
		d = q;
		for (int i = 0; i < IDP_NUM_PTR; i++) begin
			ptrLoadHi[i] = 1'b0;
			ptrLoadLo[i] = 1'b0;
			ptrStep[i]   = 1'b0;
		end
		case (q.state)
			IDP_ST_IDLE: begin
				d.pready  = 1'b0;
				d.pslverr = 1'b0;
				if (accessReq) begin
					d.isWrite = pwrite;
					d.prdata  = IDP_RDATA_RST;
					d.pready  = 1'b1;
					d.state   = IDP_ST_DONE;
					case (dec.kind)
						IDP_RK_VIRTUAL: begin
							d.pready    = 1'b0;
							d.memAddr   = calcAddr[dec.ptrIdx];
							d.memWrData = pwdata[7:0];
							d.memWrEn   = pwrite;
							d.memRdEn   = ~pwrite;
							d.state     = IDP_ST_MEMREQ;
							ptrStep[dec.ptrIdx] = stepNeeded[dec.ptrIdx];
						end
						// high part, upper bits read zero
						IDP_RK_HIGH: begin
							ptrLoadHi[dec.ptrIdx] = pwrite;
							d.prdata = {20'h0, ptrValue[dec.ptrIdx]} & 32'h0000_0F00;
							d.prdata = {24'h0, 4'h0, d.prdata[11:8]};
						end
						IDP_RK_LOW: begin
							ptrLoadLo[dec.ptrIdx] = pwrite;
							d.prdata = {24'h0, ptrValue[dec.ptrIdx][7:0]};
						end
						IDP_RK_ACCUM: begin
							if (pwrite) begin
								d.accum = pwdata[7:0];
							end
							d.prdata = {24'h0, q.accum};
						end
						IDP_RK_BANK: begin
							if (pwrite) begin
								d.bank = pwdata[IDP_BANK_W-1:0];
							end
							d.prdata = {28'h0, q.bank};
						end
						default: begin
							d.pslverr = 1'b1;
						end
					endcase
					// write transfers return zero read data, not register contents
					if (pwrite) begin
						d.prdata = IDP_RDATA_RST;
					end
				end
			end
			// strobe stands for one cycle
			IDP_ST_MEMREQ: begin
				d.memWrEn = 1'b0;
				d.memRdEn = 1'b0;
				d.state   = IDP_ST_MEMWAIT;
			end
			// memory data valid now, capture it
			IDP_ST_MEMWAIT: begin
				d.prdata = q.isWrite ? IDP_RDATA_RST : {24'h0, memRdData};
				d.pready = 1'b1;
				d.state  = IDP_ST_DONE;
			end
			// answer stands one cycle
			IDP_ST_DONE: begin
				d.pready  = 1'b0;
				d.pslverr = 1'b0;
				d.state   = IDP_ST_IDLE;
			end
			default: begin
				d.state = IDP_ST_IDLE;
			end
		endcase
	end

	// ==========================================================
	// registers; accumulator keeps no reset value
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			q.state     <= IDP_ST_IDLE;
			q.prdata    <= IDP_RDATA_RST;
			q.pready    <= 1'b0;
			q.pslverr   <= 1'b0;
			q.memAddr   <= 12'h000;
			q.memWrData <= 8'h00;
			q.memWrEn   <= 1'b0;
			q.memRdEn   <= 1'b0;
			q.isWrite   <= 1'b0;
			q.bank      <= IDP_BANK_RST;
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// outputs straight from flops
	assign prdata     = q.prdata;
	assign pready     = q.pready;
	assign pslverr    = q.pslverr;
	assign memAddr    = q.memAddr;
	assign memWrData  = q.memWrData;
	assign memWrEn    = q.memWrEn;
	assign memRdEn    = q.memRdEn;
	assign bankSelect = q.bank;

endmodule // idp_indirect_unit

// ===== core/idp_pkg.sv
// Purpose : shared constants and types for the indirect data pointer unit
// Assumes : APB byte addresses, one 32-bit word per register, 8-bit payload
// Notes   : pointer slots repeat every IDP_PTR_STRIDE bytes for pointers 0..2

package idp_pkg;

	// ==========================================================
	// widths and counts
	localparam int IDP_NUM_PTR  = 3;    // number of address pointers
	localparam int IDP_ADDR_W   = 12;   // data memory address width
	localparam int IDP_HIGH_W   = 4;    // implemented bits of pointer high part
	localparam int IDP_BANK_W   = 4;    // implemented bits of bank selector

	// ==========================================================
	// register map (byte addresses)
	localparam logic [7:0] IDP_PTR_STRIDE   = 8'h20;  // bytes per pointer block
	localparam logic [7:0] IDP_PTR_BLK_END  = 8'h60;  // first byte past pointer blocks
	localparam logic [4:0] IDP_SLOT_PLAIN   = 5'h00;  // plain indirect access
	localparam logic [4:0] IDP_SLOT_POST_INCREMENT_ACCESS = 5'h04;  // post-increment access
	localparam logic [4:0] IDP_SLOT_POST_DECREMENT_ACCESS = 5'h08;  // post-decrement access
	localparam logic [4:0] IDP_SLOT_PRE_INCREMENT_ACCESS  = 5'h0C;  // pre-increment access
	localparam logic [4:0] IDP_SLOT_INDEXED = 5'h10;  // accumulator indexed access
	localparam logic [4:0] IDP_SLOT_HIGH    = 5'h14;  // pointer high part
	localparam logic [4:0] IDP_SLOT_LOW     = 5'h18;  // pointer low part
	localparam logic [7:0] IDP_OFS_ACCUM    = 8'h60;  // working accumulator
	localparam logic [7:0] IDP_OFS_BANK     = 8'h64;  // memory bank selector

	// ==========================================================
	// reset values
	localparam logic [3:0]  IDP_PTR_HIGH_RST = 4'h0;   // pointer high part
	localparam logic [3:0]  IDP_BANK_RST     = 4'h0;   // bank selector
	localparam logic [31:0] IDP_RDATA_RST    = 32'h0;  // read data idle value

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		IDP_ST_IDLE    = 2'b00,
		IDP_ST_MEMREQ  = 2'b01,
		IDP_ST_MEMWAIT = 2'b10,
		IDP_ST_DONE    = 2'b11
	} idp_state_t;

	typedef enum logic [2:0] {
		IDP_AM_PLAIN   = 3'b000,
		IDP_AM_POST_INCREMENT_ACCESS = 3'b001,
		IDP_AM_POST_DECREMENT_ACCESS = 3'b010,
		IDP_AM_PRE_INCREMENT_ACCESS  = 3'b011,
		IDP_AM_INDEXED = 3'b100
	} idp_amode_t;

	typedef enum logic [2:0] {
		IDP_RK_NONE    = 3'b000,
		IDP_RK_VIRTUAL = 3'b001,
		IDP_RK_HIGH    = 3'b010,
		IDP_RK_LOW     = 3'b011,
		IDP_RK_ACCUM   = 3'b100,
		IDP_RK_BANK    = 3'b101
	} idp_regkind_t;

	typedef struct packed {
		idp_regkind_t kind;
		logic [1:0]   ptrIdx;
		idp_amode_t   amode;
	} idp_dec_t;

	typedef struct packed {
		logic [IDP_HIGH_W-1:0] high;
		logic [7:0]            low;
	} idp_ptr_state_t;

endpackage

// ===== core/idp_pointer.sv
// Purpose : one 12-bit indirect address pointer, high and low parts
// Assumes : step and loads never coincide in one cycle
// Notes   : low part keeps no reset value

`timescale 1ns/1ps

module idp_pointer
	import idp_pkg::*;
(
	input  wire logic        clk_sys,   // core clock
	input  wire logic        sys_rst,   // synchronous reset, active high
	input  wire logic        loadHigh,  // write high part
	input  wire logic        loadLow,   // write low part
	input  wire logic [7:0]  wrData,    // write byte
	input  wire logic        stepEn,    // move pointer by one
	input  wire logic        stepDown,  // direction of move
	output logic [11:0]      ptrValue   // full pointer
);
	import idp_pkg::*;

	idp_ptr_state_t q;
	idp_ptr_state_t d;

	assign ptrValue = {q.high, q.low};

	// ==========================================================
	// next state
	always_comb begin
		d = q;
		if (loadHigh) begin
			d.high = wrData[IDP_HIGH_W-1:0];
		end
		if (loadLow) begin
			d.low = wrData;
		end
		// steps carry across the 12-bit pointer
		if (stepEn) begin
			if (stepDown) begin
				{d.high, d.low} = 12'({q.high, q.low} - 12'h001);
			end else begin
				{d.high, d.low} = 12'({q.high, q.low} + 12'h001);
			end
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			q.high <= IDP_PTR_HIGH_RST;
		end else begin
			q <= d;
		end
	end

endmodule // idp_pointer

// ===== sim/idp_mem_model.sv
// Purpose : data memory at the far side of the pointer unit
// Assumes : read byte shown in the cycle after the read strobe
// Notes   : outside that cycle the read bus changes every cycle
`timescale 1ns/1ps

// ==========================================================
// data memory model
module idp_mem_model (
	input  wire logic        clk_sys,   // core clock
	input  wire logic [11:0] memAddr,   // access address
	input  wire logic [7:0]  memWrData, // write byte
	input  wire logic        memWrEn,   // write strobe
	input  wire logic        memRdEn,   // read strobe
	output logic      [7:0]  memRdData  // read byte
);
	logic [7:0] mem [4096];
	// address-derived fill pattern
	initial begin
		for (int i = 0; i < 4096; i++) begin
			mem[i] = 8'(i) ^ 8'h5A;
		end
	end
	// store writes, answer reads one cycle on, scramble when idle
	always @(posedge clk_sys) begin
		if (memWrEn) begin
			mem[memAddr] <= memWrData;
		end
		memRdData <= memRdEn ? mem[memAddr] : ~memRdData;
	end
endmodule // idp_mem_model

// ===== sim/idp_props.sv
// Purpose : port checks for the indirect pointer unit
// Assumes : one APB transfer at a time
// Notes   : attached by bind below
`timescale 1ns/1ps

// ==========================================================
// checker
module idp_props (
	input wire logic        clk_sys,   // core clock
	input wire logic        sys_rst,   // reset
	input wire logic        psel,      // select
	input wire logic        penable,   // access phase
	input wire logic        pwrite,    // direction
	input wire logic [7:0]  paddr,     // address
	input wire logic [31:0] pwdata,    // write data
	input wire logic [31:0] prdata,    // read data
	input wire logic        pready,    // ready
	input wire logic        pslverr,   // error
	input wire logic [11:0] memAddr,   // memory address
	input wire logic [7:0]  memWrData, // memory write byte
	input wire logic        memWrEn,   // write strobe
	input wire logic        memRdEn,   // read strobe
	input wire logic [7:0]  memRdData  // memory read byte
);
	import idp_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// access phase and address classes
	wire logic acc = psel && penable;
	wire logic blk = paddr < IDP_PTR_BLK_END;
	wire logic virt = blk && paddr[4:0] <= IDP_SLOT_INDEXED && paddr[1:0] == 2'b00;
	property p_virt;
		acc && !$past(penable) && virt |=> (memRdEn || memWrEn) ##2 pready;
	endproperty
	a_virt: assert property (p_virt) else $error("virtual access timing");
	property p_reg;
		acc && !$past(penable) && !virt |=> pready && !memRdEn && !memWrEn;
	endproperty
	a_reg: assert property (p_reg) else $error("register access timing");
	property p_hi;
		acc && !$past(penable) && !pwrite && blk && paddr[4:0] == IDP_SLOT_HIGH
			|=> prdata[31:4] == 28'h0;
	endproperty
	a_hi: assert property (p_hi) else $error("high part too wide");
	property p_rd;
		memRdEn |-> ##2 pready && prdata == {24'h0, $past(memRdData)};
	endproperty
	a_rd: assert property (p_rd) else $error("read byte not returned");
	property p_wr;
		memWrEn |-> memWrData == pwdata[7:0] ##2 pready && prdata == 32'h0;
	endproperty
	a_wr: assert property (p_wr) else $error("write byte or answer wrong");
	property p_rdir;
		memRdEn |-> !pwrite && !memWrEn;
	endproperty
	a_rdir: assert property (p_rdir) else $error("read strobe on write");
	property p_wen;
		memWrEn |-> pwrite && $past(acc);
	endproperty
	a_wen: assert property (p_wen) else $error("write strobe without request");
	property p_addr;
		!$stable(memAddr) |-> memRdEn || memWrEn;
	endproperty
	a_addr: assert property (p_addr) else $error("address moved idle");
	c_rd: cover property (memRdEn);
	c_wr: cover property (memWrEn);
	c_err: cover property (pslverr);
endmodule // idp_props

bind idp_indirect_unit idp_props i_idp_props (.clk_sys, .sys_rst, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .memAddr, .memWrData,
	.memWrEn, .memRdEn, .memRdData);

// ===== sim/indirect_data_pointer_unit_test.sv
// Purpose : self-checking bench for the indirect pointer unit
// Assumes : APB master, memory model on the far side
// Notes   : reference model of pointers and memory kept in the bench
`timescale 1ns/1ps

// ==========================================================
// bench top
module indirect_data_pointer_unit_test;
	import idp_pkg::*;
	logic        clk_sys = 1'b0;
	logic        sys_rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rdv;
	logic [11:0] memAddr;
	logic [7:0]  memWrData, memRdData, acc;
	logic [3:0]  bankSelect;
	logic        pready, pslverr, memWrEn, memRdEn, errv;
	logic [11:0] ptr [3];
	logic [11:0] pv;
	logic [7:0]  mem [4096];
	logic [11:0] bv [4] = '{12'h0FF, 12'hFFF, 12'h000, 12'hF80};
	int          bm [4] = '{1, 3, 2, 4};
	int          nMismatch = 0;
	int          totalChecks = 0;
	// 40 MHz clock
	always #12.5 clk_sys = ~clk_sys;
	idp_indirect_unit i_idp_indirect_unit (.clk_sys, .sys_rst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .memAddr, .memWrData, .memWrEn,
		.memRdEn, .memRdData, .bankSelect);
	idp_mem_model i_idp_mem_model (.clk_sys, .memAddr, .memWrData, .memWrEn, .memRdEn,
		.memRdData);
	// verdict
	task automatic finishTest();
		$display("checks %0d mismatches %0d", totalChecks, nMismatch);
		if (nMismatch == 0 && totalChecks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// compare tasks
	task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
		totalChecks++;
		if (got !== exp) begin
			nMismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chkFlag(input logic got, input logic exp);
		totalChecks++;
		if (got !== exp) begin
			nMismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one APB transfer, bounded wait for pready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			nMismatch++;
			finishTest();
		end
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic setPtr(input int n, input logic [11:0] v);
		apb(1'b1, 8'(n * 32) + IDP_SLOT_HIGH, {28'hFFFFFFF, v[11:8]});
		apb(1'b1, 8'(n * 32) + IDP_SLOT_LOW, {24'hFFFFFF, v[7:0]});
		ptr[n] = v;
	endtask
	task automatic rdPtr(input int n);
		apb(1'b0, 8'(n * 32) + IDP_SLOT_HIGH, 32'h0);
		chkVal(rdv, {28'h0, ptr[n][11:8]});
		apb(1'b0, 8'(n * 32) + IDP_SLOT_LOW, 32'h0);
		chkVal(rdv, {24'h0, ptr[n][7:0]});
	endtask
	task automatic setAcc(input logic [7:0] v);
		acc = v;
		apb(1'b1, IDP_OFS_ACCUM, {24'h0, v});
		apb(1'b0, IDP_OFS_ACCUM, 32'h0);
		chkVal(rdv, {24'h0, v});
	endtask
	// one virtual access checked against the reference
	task automatic vacc(input int n, input int m, input logic wr, input logic [7:0] d);
		logic [11:0] ea;
		ea = (m == 4) ? ptr[n] + {4'h0, acc} : (m == 3) ? ptr[n] + 12'h001 : ptr[n];
		ptr[n] = ptr[n] + ((m == 1 || m == 3) ? 12'h001 : (m == 2) ? 12'hFFF : 12'h000);
		apb(wr, 8'(n * 32 + m * 4), {24'h0, d});
		chkVal(rdv, wr ? 32'h0 : {24'h0, mem[ea]});
		chkVal({20'h0, memAddr}, {20'h0, ea});
		chkFlag(errv, 1'b0);
		if (wr) begin
			chkVal({24'h0, memWrData}, {24'h0, d});
			mem[ea] = d;
		end
		rdPtr(n);
	endtask
	task automatic chkReset();
		for (int n = 0; n < 3; n++) begin
			apb(1'b0, 8'(n * 32) + IDP_SLOT_HIGH, 32'h0);
			chkVal(rdv, {28'h0, IDP_PTR_HIGH_RST});
		end
		apb(1'b0, IDP_OFS_BANK, 32'h0);
		chkVal(rdv, {28'h0, IDP_BANK_RST});
		$display("test reset done");
	endtask
	// main sequence
	initial begin
		void'($urandom(32'h64340c89));
		for (int i = 0; i < 4096; i++) begin
			mem[i] = 8'(i) ^ 8'h5A;
		end
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		chkReset();
		setAcc(8'($urandom));
		for (int n = 0; n < 3; n++) begin
			for (int m = 0; m < 5; m++) begin
				// same pointer twice so the read returns the written byte
				pv = 12'($urandom);
				setPtr(n, pv);
				vacc(n, m, 1'b1, 8'($urandom));
				setPtr(n, pv);
				vacc(n, m, 1'b0, 8'h00);
			end
		end
		$display("test modes done");
		setAcc(8'hFF);
		for (int i = 0; i < 4; i++) begin
			setPtr(i % 3, bv[i]);
			vacc(i % 3, bm[i], 1'(i), 8'h3C);
		end
		foreach (bv[i]) begin
			// unused slots of the pointer blocks and space above the bank selector
			apb(1'(i), 8'h1C + 8'(i * 64), 32'h0);
			chkFlag(errv, 1'b1);
			chkVal(rdv, 32'h0);
		end
		// bank selector keeps four bits and shows them on its output
		pv = 12'($urandom);
		apb(1'b1, IDP_OFS_BANK, {20'hFFFFF, pv});
		apb(1'b0, IDP_OFS_BANK, 32'h0);
		chkVal(rdv, {28'h0, pv[3:0]});
		chkVal({28'h0, bankSelect}, {28'h0, pv[3:0]});
		$display("test edges done");
		for (int i = 0; i < 40; i++) begin
			if (i % 8 == 0) begin
				setAcc(8'($urandom));
			end
			vacc($urandom % 3, $urandom % 5, 1'($urandom), 8'($urandom));
		end
		$display("test random done");
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		chkReset();
		chkVal({28'h0, bankSelect}, {28'h0, IDP_BANK_RST});
		finishTest();
	end
endmodule // indirect_data_pointer_unit_test
